// file: prm_pkg.sv
// Overview of operation
// - All registers 16 bits, four pages
// - Results, measurement, audio, buffer pages in order
// - Result offsets 05, 07, 08, 09, 0A
// - Each conversion lands in its result register
// - Results reset to zero, host read-only
// - Results right-justified, top nibble zero
// - Read and write meanings decoded separately
// - Buffer page 00 to 3F holds samples
// - Audio page coefficients, multiplier, pin control
// - Audio page 00 to 27, rest reserved
// - Command word: direction, page, index, zeros
// - Pointer advances; past page end reads ones
package prm_pkg;
  localparam int          WORD_W         = 16;
  localparam int          PAGE_W         = 4;
  localparam int          ADDR_W         = 6;
  localparam int          RES_W          = 12;
  localparam int          NUM_RES        = 5;
  localparam int          CMD_RW_BIT     = 15;
  localparam int          CMD_PG_MSB     = 14;
  localparam int          CMD_PG_LSB     = 11;
  localparam int          CMD_AD_MSB     = 10;
  localparam int          CMD_AD_LSB     = 5;
  localparam int          CTRL_STAT_BIT  = 14;
  localparam logic [3:0]  PG_RESULT      = 4'h0;
  localparam logic [3:0]  PG_MEAS        = 4'h1;
  localparam logic [3:0]  PG_AUDIO       = 4'h2;
  localparam logic [3:0]  PG_BUF         = 4'h3;
  localparam logic [5:0]  SUPPLY_CELL_RESULT_OFS   = 6'h05;
  localparam logic [5:0]  AUX_A_RESULT_OFS         = 6'h07;
  localparam logic [5:0]  AUX_B_RESULT_OFS         = 6'h08;
  localparam logic [5:0]  THERM_A_RESULT_OFS       = 6'h09;
  localparam logic [5:0]  THERM_B_RESULT_OFS       = 6'h0a;
  localparam logic [5:0]  RES_OFS [NUM_RES] = '{SUPPLY_CELL_RESULT_OFS, AUX_A_RESULT_OFS,
                                               AUX_B_RESULT_OFS, THERM_A_RESULT_OFS, THERM_B_RESULT_OFS};
  localparam logic [5:0]  CONV_CTRL_OFS  = 6'h00;
  localparam logic [5:0]  P1_LAST        = 6'h0d;
  localparam logic [5:0]  P2_COEF_FIRST  = 6'h07;
  localparam logic [5:0]  P2_COEF_LAST   = 6'h1a;
  localparam logic [5:0]  P2_PLL_A       = 6'h1b;
  localparam logic [5:0]  P2_PLL_B       = 6'h1c;
  localparam logic [5:0]  P2_CELL_GAIN   = 6'h1f;
  localparam logic [5:0]  P2_PIN_CTRL    = 6'h23;
  localparam logic [5:0]  P2_LAST        = 6'h27;
  localparam logic [15:0] RESULT_RST     = 16'h0000;
  localparam logic [15:0] CTRL_RST       = 16'h0000;
  localparam logic [15:0] PAST_END       = 16'hffff;
  localparam logic [15:0] RSV_READ       = 16'h0000;
  localparam logic [3:0]  BIT_LAST       = 4'hf;

  typedef enum logic [2:0] {
    CH_SUPPLY = 3'b000, CH_AUX_A = 3'b001, CH_AUX_B = 3'b010,
    CH_THERM_A = 3'b011, CH_THERM_B = 3'b100
  } chan_e;
  typedef enum logic {PH_CMD = 1'b0, PH_DATA = 1'b1} phase_e;
  typedef struct packed {
    logic        valid;
    chan_e       chan;
    logic [11:0] data;
  } conv_s;
  typedef struct packed {
    logic        valid;
    logic [5:0]  slot;
    logic [15:0] data;
  } sample_s;
  typedef struct packed {
    logic        valid;
    logic [3:0]  page;
    logic [5:0]  addr;
    logic [15:0] data;
  } ctrl_wr_s;
endpackage : prm_pkg

// file: paged_register_map_results.sv
`timescale 1ns/1ps
`default_nettype none
module paged_register_map_results
  import prm_pkg::*;
(
  // Clock and reset
  input  wire logic     sys_clk,
  input  wire logic     rst_n,
  // Serial pins
  input  wire logic     spi_sclk,
  input  wire logic     spi_cs_n,
  input  wire logic     spi_mosi,
  output var  logic     spi_miso,
  output var  logic     spi_miso_oe,
  // Converter side
  input  wire conv_s    conv,
  input  wire sample_s  sample,
  input  wire logic     converter_idle,
  // Control effects
  output var  ctrl_wr_s ctrl_wr,
  output var  logic     conv_stop
);
  localparam int P1_WORDS  = int'(P1_LAST) + 1;
  localparam int P2_WORDS  = int'(P2_LAST) + 1;
  localparam int BUF_WORDS = 1 << ADDR_W;

  // Pin synchroniser stages
  logic [2:0]  sclk_ff;
  logic [2:0]  cs_ff;
  logic [1:0]  mosi_ff;
  // Frame state
  phase_e      phase_ff;
  phase_e      nxt_phase_ff;
  logic [3:0]  cnt_ff;
  logic [3:0]  nxt_cnt_ff;
  logic [15:0] rx_ff;
  logic [15:0] nxt_rx_ff;
  logic [15:0] tx_ff;
  logic [15:0] nxt_tx_ff;
  logic        miso_ff;
  logic        nxt_miso_ff;
  logic        wr_ff;
  logic        nxt_wr_ff;
  logic        past_ff;
  logic        nxt_past_ff;
  logic [3:0]  page_ff;
  logic [3:0]  nxt_page_ff;
  logic [5:0]  ptr_ff;
  logic [5:0]  nxt_ptr_ff;
  ctrl_wr_s    cw_ff;
  ctrl_wr_s    nxt_cw_ff;
  logic        stop_ff;
  logic        nxt_stop_ff;
  // Register storage
  logic [11:0] res_ff     [NUM_RES];
  logic [11:0] nxt_res_ff [NUM_RES];
  logic [15:0] p1_ff      [P1_WORDS];
  logic [15:0] nxt_p1_ff  [P1_WORDS];
  logic [15:0] p2_ff      [P2_WORDS];
  logic [15:0] nxt_p2_ff  [P2_WORDS];
  logic [15:0] buf_ff     [BUF_WORDS];
  logic [15:0] nxt_buf_ff [BUF_WORDS];
  // Per-cycle strobes
  logic        fall;
  logic        rise;
  logic        ld;
  logic        word_end;
  logic        wr_go;
  logic [15:0] rx_w;
  logic [6:0]  ptr_inc;

  // Read value; the status bit of word 00 reads differently from what was written
  function automatic logic [15:0] rd_word(input logic [3:0] pg, input logic [5:0] a,
                                          input logic past, input logic idle);
    logic [15:0] w;
    w = RSV_READ;
    if (past) begin
      w = PAST_END;
    end else if (pg == PG_RESULT) begin
      for (int i = 0; i < NUM_RES; i++) begin
        if (a == RES_OFS[i]) begin
          w = {{(WORD_W-RES_W){1'b0}}, res_ff[i]};
        end
      end
    end else if (pg == PG_MEAS && a <= P1_LAST) begin
      w = p1_ff[a[3:0]];
      if (a == CONV_CTRL_OFS) begin
        w[CTRL_STAT_BIT] = idle;
      end
    end else if (pg == PG_AUDIO && a <= P2_LAST) begin
      w = p2_ff[a];
    end else if (pg == PG_BUF) begin
      w = buf_ff[a];
    end
    return w;
  endfunction : rd_word

  // Pin synchronisers; edge detect uses stages two and three
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      sclk_ff <= 3'h0;
      cs_ff   <= 3'h7;
      mosi_ff <= 2'h0;
    end else begin
      sclk_ff <= {sclk_ff[1:0], spi_sclk};
      cs_ff   <= {cs_ff[1:0], spi_cs_n};
      mosi_ff <= {mosi_ff[0], spi_mosi};
    end
  end

  assign fall    = sclk_ff[2] && !sclk_ff[1];
  assign rise    = !sclk_ff[2] && sclk_ff[1];
  assign rx_w    = {rx_ff[14:0], mosi_ff[1]};
  assign ptr_inc = {1'b0, ptr_ff} + 7'h01;

  always_comb begin
    nxt_phase_ff = phase_ff;
    nxt_cnt_ff   = cnt_ff;
    nxt_rx_ff    = rx_ff;
    nxt_tx_ff    = tx_ff;
    nxt_miso_ff  = miso_ff;
    nxt_wr_ff    = wr_ff;
    nxt_past_ff  = past_ff;
    nxt_page_ff  = page_ff;
    nxt_ptr_ff   = ptr_ff;
    nxt_cw_ff    = '0;
    nxt_stop_ff  = 1'b0;
    ld           = 1'b0;
    word_end     = 1'b0;
    wr_go        = 1'b0;
    // Only words after a select falling edge count
    if (cs_ff[1] || cs_ff[2]) begin
      nxt_phase_ff = PH_CMD;
      nxt_cnt_ff   = 4'h0;
      nxt_miso_ff  = 1'b0;
    end else if (fall) begin
      nxt_rx_ff  = rx_w;
      nxt_cnt_ff = cnt_ff + 4'h1;
      if (cnt_ff == BIT_LAST) begin
        ld = 1'b1;
        if (phase_ff == PH_CMD) begin
          nxt_phase_ff = PH_DATA;
          nxt_wr_ff    = !rx_w[CMD_RW_BIT];
          nxt_page_ff  = rx_w[CMD_PG_MSB:CMD_PG_LSB];
          nxt_ptr_ff   = rx_w[CMD_AD_MSB:CMD_AD_LSB];
          nxt_past_ff  = 1'b0;
        end else begin
          word_end    = 1'b1;
          wr_go       = wr_ff && !past_ff;
          nxt_ptr_ff  = ptr_inc[5:0];
          nxt_past_ff = past_ff || ptr_inc[6];
        end
        nxt_tx_ff = rd_word(nxt_page_ff, nxt_ptr_ff, nxt_past_ff, converter_idle);
      end
    end else if (rise) begin
      nxt_miso_ff = (phase_ff == PH_DATA) && !wr_ff && tx_ff[15];
      nxt_tx_ff   = {tx_ff[14:0], 1'b1};
    end
    // Writes only reach the two control pages
    if (wr_go && ((page_ff == PG_MEAS && ptr_ff <= P1_LAST) ||
                  (page_ff == PG_AUDIO && ptr_ff <= P2_LAST))) begin
      nxt_cw_ff = '{valid: 1'b1, page: page_ff, addr: ptr_ff, data: rx_w};
      nxt_stop_ff = (page_ff == PG_MEAS) && (ptr_ff == CONV_CTRL_OFS) && rx_w[CTRL_STAT_BIT];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      phase_ff <= PH_CMD;
      cnt_ff   <= 4'h0;
      rx_ff    <= 16'h0000;
      tx_ff    <= 16'h0000;
      miso_ff  <= 1'b0;
      wr_ff    <= 1'b0;
      past_ff  <= 1'b0;
      page_ff  <= 4'h0;
      ptr_ff   <= 6'h00;
      cw_ff    <= '0;
      stop_ff  <= 1'b0;
    end else begin
      phase_ff <= nxt_phase_ff;
      cnt_ff   <= nxt_cnt_ff;
      rx_ff    <= nxt_rx_ff;
      tx_ff    <= nxt_tx_ff;
      miso_ff  <= nxt_miso_ff;
      wr_ff    <= nxt_wr_ff;
      past_ff  <= nxt_past_ff;
      page_ff  <= nxt_page_ff;
      ptr_ff   <= nxt_ptr_ff;
      cw_ff    <= nxt_cw_ff;
      stop_ff  <= nxt_stop_ff;
    end
  end

  // Control pages; only the stop bit of word 00 is a command, stored as zero
  always_comb begin
    nxt_p1_ff = p1_ff;
    nxt_p2_ff = p2_ff;
    if (nxt_cw_ff.valid) begin
      if (page_ff == PG_MEAS) begin
        nxt_p1_ff[ptr_ff[3:0]] = rx_w;
        if (ptr_ff == CONV_CTRL_OFS) begin
          nxt_p1_ff[ptr_ff[3:0]][CTRL_STAT_BIT] = 1'b0;
        end
      end else begin
        nxt_p2_ff[ptr_ff] = rx_w;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < P1_WORDS; i++) p1_ff[i] <= CTRL_RST;
      for (int i = 0; i < P2_WORDS; i++) p2_ff[i] <= CTRL_RST;
    end else begin
      p1_ff <= nxt_p1_ff;
      p2_ff <= nxt_p2_ff;
    end
  end

  // Sample buffer, written by the converter only
  always_comb begin
    nxt_buf_ff = buf_ff;
    if (sample.valid) begin
      nxt_buf_ff[sample.slot] = sample.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < BUF_WORDS; i++) buf_ff[i] <= CTRL_RST;
    end else begin
      buf_ff <= nxt_buf_ff;
    end
  end

  // Result registers; kept until the next conversion of that input
  for (genvar g = 0; g < NUM_RES; g++) begin : g_res
    always_comb begin
      nxt_res_ff[g] = res_ff[g];
      if (conv.valid && conv.chan == chan_e'(g)) begin
        nxt_res_ff[g] = conv.data;
      end
    end

    always_ff @(posedge sys_clk) begin
      if (!rst_n) begin
        res_ff[g] <= RESULT_RST[RES_W-1:0];
      end else begin
        res_ff[g] <= nxt_res_ff[g];
      end
    end
  end

  assign spi_miso    = miso_ff;
  assign spi_miso_oe = !cs_ff[1];
  assign ctrl_wr     = cw_ff;
  assign conv_stop   = stop_ff;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  result_store_a: assert property (conv.valid && conv.chan == CH_AUX_B |=>
    res_ff[2] == $past(conv.data)) else $error("result not stored");
  result_reset_a: assert property ($rose(rst_n) |-> res_ff[0] == 12'h000 &&
    res_ff[4] == 12'h000) else $error("result not cleared by reset");
  result_justify_a: assert property (ld && !nxt_past_ff && nxt_page_ff == PG_RESULT |=>
    tx_ff[15:12] == 4'h0) else $error("result top bits not zero");
  cmd_quiet_a: assert property (phase_ff == PH_CMD |-> !miso_ff)
    else $error("output driven during command");
  ptr_advance_a: assert property (word_end |=> ptr_ff == $past(ptr_ff) + 6'h01)
    else $error("pointer did not advance");
  past_end_a: assert property (ld && nxt_past_ff |=> (tx_ff == PAST_END) [*2])
    else $error("past end word not all ones");
  ctrl_stop_a: assert property (wr_go && page_ff == PG_MEAS && ptr_ff == CONV_CTRL_OFS &&
    rx_w[CTRL_STAT_BIT] |=> conv_stop ##1 !conv_stop) else $error("stop command lost");
  ro_write_a: assert property (wr_go && (page_ff == PG_RESULT || page_ff == PG_BUF) |=>
    !ctrl_wr.valid) else $error("read-only write accepted");
  audio_rsv_a: assert property (ld && !nxt_past_ff && nxt_page_ff == PG_AUDIO &&
    nxt_ptr_ff > P2_LAST |=> tx_ff == RSV_READ) else $error("reserved audio read not zero");
  buffer_store_a: assert property (sample.valid ##1 !sample.valid |->
    buf_ff[$past(sample.slot)] == $past(sample.data)) else $error("sample not stored");
  write_lands_a: assert property (nxt_cw_ff.valid && page_ff == PG_AUDIO |=>
    p2_ff[$past(ptr_ff)] == $past(rx_w)) else $error("audio word not stored");
  stat_cleared_a: assert property (nxt_cw_ff.valid && page_ff == PG_MEAS && ptr_ff == CONV_CTRL_OFS |=>
    !p1_ff[0][CTRL_STAT_BIT]) else $error("stop bit stored");
  meas_write_a: assert property (nxt_cw_ff.valid && page_ff == PG_MEAS && ptr_ff != CONV_CTRL_OFS |=>
    p1_ff[$past(ptr_ff[3:0])] == $past(rx_w)) else $error("measurement word not stored");
  past_write_a: assert property (word_end && wr_ff && past_ff |=> !ctrl_wr.valid)
    else $error("write past page end accepted");
  miso_idle_a: assert property (cs_ff[2] |=> !spi_miso)
    else $error("return line busy while deselected");
  result_hold_a: assert property (!conv.valid |=> res_ff[0] == $past(res_ff[0]) &&
    res_ff[4] == $past(res_ff[4])) else $error("result changed without conversion");
  rsv_page_a: assert property (ld && !nxt_past_ff && nxt_page_ff > PG_BUF |=> tx_ff == RSV_READ)
    else $error("reserved page read not zero");
  result_read_a: assert property (ld && !nxt_past_ff && nxt_page_ff == PG_RESULT &&
    nxt_ptr_ff == SUPPLY_CELL_RESULT_OFS |=> tx_ff == {4'h0, $past(res_ff[0])}) else $error("supply misread");
  stop_only_a: assert property (!nxt_cw_ff.valid |=> !conv_stop)
    else $error("stop without accepted write");
  cw_pulse_a: assert property (ctrl_wr.valid |=> !ctrl_wr.valid)
    else $error("write strobe longer than one cycle");
endmodule : paged_register_map_results
`default_nettype wire

// file: spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model #(
  parameter int HALF = 8
) (
  // Clock
  input  wire logic        sys_clk,
  // Serial pins
  output var  logic        spi_sclk,
  output var  logic        spi_cs_n,
  output var  logic        spi_mosi,
  input  wire logic        spi_miso,
  // Word seen on the return line
  output var  logic        rx_stb,
  output var  logic [15:0] rx_word
);
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
    rx_stb   = 1'b0;
    rx_word  = 16'h0000;
  end
  // A fresh falling select starts every command
  task automatic sel(input logic on);
    repeat (HALF) @(posedge sys_clk);
    #1 spi_cs_n = ~on;
  endtask : sel
  // Clock idles low, data out on rise, return line sampled on fall
  task automatic xfer(input logic [15:0] tx);
    for (int i = 15; i >= 0; i--) begin
      repeat (HALF) @(posedge sys_clk);
      #1 spi_sclk = 1'b1;
      spi_mosi = tx[i];
      repeat (HALF) @(posedge sys_clk);
      #1 spi_sclk = 1'b0;
      rx_word[i] = spi_miso;
    end
    @(posedge sys_clk);
    #1 rx_stb = 1'b1;
    @(posedge sys_clk);
    #1 rx_stb = 1'b0;
  endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// file: tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import prm_pkg::*;
;
  logic        sys_clk, rst_n, converter_idle;
  logic        spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe, conv_stop, rx_stb;
  conv_s       conv;
  sample_s     sample;
  ctrl_wr_s    ctrl_wr;
  logic [15:0] rx_word, d, r[4], res[NUM_RES];
  logic [15:0] exp_rd[$];
  ctrl_wr_s    exp_wr[$];
  logic [5:0]  a, b;
  logic [3:0]  pg;
  int          mismatches = 0, total_checks = 0, stops = 0, cycles = 0, seed = 89;

  always #4 sys_clk = ~sys_clk;

  paged_register_map_results DUT (.sys_clk, .rst_n, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso,
    .spi_miso_oe, .conv, .sample, .converter_idle, .ctrl_wr, .conv_stop);
  spi_host_model host (.sys_clk, .spi_sclk, .spi_cs_n, .spi_mosi, .spi_miso, .rx_stb, .rx_word);

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (exp !== got) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  function automatic logic [15:0] cmd(input logic rd, input logic [3:0] p, input logic [5:0] ad);
    return {rd, p, ad, 5'h00};
  endfunction : cmd

  task automatic word(input logic [15:0] tx, input logic [15:0] exp);
    exp_rd.push_back(exp);
    host.xfer(tx);
  endtask : word

  // Two data words back to back, so the pointer step is exercised
  task automatic wr(input logic [3:0] p, input logic [5:0] ad, input logic [15:0] v0, input logic ok0,
                    input logic [15:0] v1, input logic ok1);
    host.sel(1'b1);
    word(cmd(1'b0, p, ad), 16'h0000);
    if (ok0) exp_wr.push_back({1'b1, p, ad, v0});
    if (ok1) exp_wr.push_back({1'b1, p, ad + 6'h01, v1});
    word(v0, 16'h0000);
    word(v1, 16'h0000);
    host.sel(1'b0);
  endtask : wr

  task automatic rd2(input logic [3:0] p, input logic [5:0] ad, input logic [15:0] e0, input logic [15:0] e1);
    host.sel(1'b1);
    word(cmd(1'b1, p, ad), 16'h0000);
    word(16'h0000, e0);
    word(16'h0000, e1);
    host.sel(1'b0);
  endtask : rd2

  // Watcher: every result that shows takes the oldest note
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      stop_test();
    end
    if (rx_stb === 1'b1) begin
      check("miso_oe", 32'h1, spi_miso_oe);
      check("read word", exp_rd.pop_front(), rx_word);
    end
    if (ctrl_wr.valid === 1'b1) check("ctrl_wr", exp_wr.pop_front(), ctrl_wr);
    if (conv_stop === 1'b1) stops++;
  end

  initial begin
    sys_clk        = 1'b0;
    rst_n          = 1'b0;
    converter_idle = 1'b0;
    conv           = '0;
    sample         = '0;
    for (int i = 0; i < 4; i++) r[i] = 16'($random(seed));
    repeat (8) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge sys_clk);
    host.sel(1'b1);
    word(cmd(1'b1, PG_RESULT, SUPPLY_CELL_RESULT_OFS), 16'h0000);
    for (int i = 0; i < 6; i++) word(16'h0000, 16'h0000);
    host.sel(1'b0);
    for (int c = 0; c < NUM_RES; c++) begin
      @(posedge sys_clk);
      #1 conv = '{1'b1, chan_e'(c), 12'($random(seed))};
      res[c] = {4'h0, conv.data};
      @(posedge sys_clk);
      #1 conv.valid = 1'b0;
    end
    // Whole result page, then two words past its end
    host.sel(1'b1);
    word(cmd(1'b1, PG_RESULT, 6'h00), 16'h0000);
    for (int i = 0; i < 66; i++) begin
      d = 16'h0000;
      for (int c = 0; c < NUM_RES; c++) if (6'(i) == RES_OFS[c] && i < 64) d = res[c];
      word(16'h0000, i > 63 ? 16'hffff : d);
    end
    host.sel(1'b0);
    wr(PG_RESULT, SUPPLY_CELL_RESULT_OFS, r[0], 1'b0, r[1], 1'b0);
    rd2(PG_RESULT, SUPPLY_CELL_RESULT_OFS, res[0], 16'h0000);
    for (int p = 0; p < 2; p++) begin
      pg = p ? PG_AUDIO : PG_MEAS;
      a = p ? P2_COEF_LAST : 6'h0c;
      b = p ? P2_LAST : P1_LAST;
      wr(pg, a, r[0], 1'b1, r[1], 1'b1);
      wr(pg, b, r[2], 1'b1, r[3], 1'b0);
      rd2(pg, a, r[0], a + 6'h01 == b ? r[2] : r[1]);
      rd2(pg, b, r[2], 16'h0000);
    end
    d = {2'b00, r[3][13:0]};
    converter_idle = r[3][0];
    wr(PG_MEAS, CONV_CTRL_OFS, d | 16'h4000, 1'b1, 16'h0000, 1'b1);
    rd2(PG_MEAS, CONV_CTRL_OFS, {1'b0, converter_idle, d[13:0]}, 16'h0000);
    converter_idle = ~converter_idle;
    rd2(PG_MEAS, CONV_CTRL_OFS, {1'b0, converter_idle, d[13:0]}, 16'h0000);
    @(posedge sys_clk);
    #1 sample = '{1'b1, 6'h3f, 16'($random(seed))};
    d = sample.data;
    @(posedge sys_clk);
    #1 sample.valid = 1'b0;
    wr(PG_BUF, 6'h3f, r[0], 1'b0, r[1], 1'b0);
    rd2(PG_BUF, 6'h3e, 16'h0000, d);
    rd2(PG_BUF, 6'h3f, d, 16'hffff);
    rd2(4'h4, 6'h00, 16'h0000, 16'h0000);
    // Second reset in mid-run clears the results again
    @(posedge sys_clk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge sys_clk);
    #1 rst_n = 1'b1;
    rd2(PG_RESULT, THERM_A_RESULT_OFS, 16'h0000, 16'h0000);
    repeat (20) @(posedge sys_clk);
    check("miso_oe idle", 32'h0, spi_miso_oe);
    check("stop pulses", 32'h1, stops);
    check("notes left", 32'h0, exp_rd.size() + exp_wr.size());
    stop_test();
  end
endmodule : tb_top
`default_nettype wire
